// *** pkg/tc0_pkg.sv ***
/*
  Shared constants of the 8-bit timer/counter core: register offsets,
  field positions, reset values, mode and action codes.
  Assumes a 32-bit AXI4-Lite register bus with one byte-wide register per word.
*/
package tc0_pkg;
  // Bus geometry and answers
  localparam int unsigned TC0_ADDR_W   = 6;
  localparam logic [1:0]  TC0_RESP_OK  = 2'h0;
  localparam logic [1:0]  TC0_RESP_ERR = 2'h2;
  // Register byte addresses
  localparam logic [5:0] TC0_OFF_CTRL_A = 6'h00;
  localparam logic [5:0] TC0_OFF_CTRL_B = 6'h04;
  localparam logic [5:0] TC0_OFF_COUNT  = 6'h08;
  localparam logic [5:0] TC0_OFF_CMP_A  = 6'h0C;
  localparam logic [5:0] TC0_OFF_CMP_B  = 6'h10;
  localparam logic [5:0] TC0_OFF_MASK   = 6'h14;
  localparam logic [5:0] TC0_OFF_FLAG   = 6'h18;
  localparam logic [5:0] TC0_OFF_POWER  = 6'h1C;
  // Field positions in control register A
  localparam int unsigned TC0_CA_ACT_A = 6;
  localparam int unsigned TC0_CA_ACT_B = 4;
  localparam int unsigned TC0_CA_WAVE  = 0;
  // Field positions in control register B
  localparam int unsigned TC0_CB_FORCE_A = 7;
  localparam int unsigned TC0_CB_FORCE_B = 6;
  localparam int unsigned TC0_CB_WAVE2   = 3;
  localparam int unsigned TC0_CB_CS      = 0;
  // Flag, mask and power bit positions
  localparam int unsigned TC0_FL_OVF   = 0;
  localparam int unsigned TC0_FL_CMP_A = 1;
  localparam int unsigned TC0_FL_CMP_B = 2;
  localparam int unsigned TC0_PWR_OFF  = 0;
  // Reset values
  localparam logic [7:0] TC0_RST_BYTE  = 8'h00;
  localparam logic [2:0] TC0_RST_FLAGS = 3'h0;
  localparam logic       TC0_RST_PWR   = 1'b0;
  // Count extremes
  localparam logic [7:0] TC0_BOTTOM = 8'h00;
  localparam logic [7:0] TC0_MAX    = 8'hFF;
  // Waveform mode codes
  localparam logic [2:0] TC0_WAVE_NORMAL = 3'h0;
  localparam logic [2:0] TC0_WAVE_CTC    = 3'h2;
  localparam logic [2:0] TC0_WAVE_FAST   = 3'h3;
  localparam logic [2:0] TC0_WAVE_FAST_A = 3'h7;
  // Compare output action codes
  localparam logic [1:0] TC0_ACT_NONE   = 2'h0;
  localparam logic [1:0] TC0_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TC0_ACT_CLEAR  = 2'h2;
  localparam logic [1:0] TC0_ACT_SET    = 2'h3;
  // Clock select codes and prescaler taps (log2 of the divisor)
  localparam logic [2:0]  TC0_CS_STOP     = 3'h0;
  localparam logic [2:0]  TC0_CS_DIV1     = 3'h1;
  localparam logic [2:0]  TC0_CS_DIV8     = 3'h2;
  localparam logic [2:0]  TC0_CS_DIV64    = 3'h3;
  localparam logic [2:0]  TC0_CS_DIV256   = 3'h4;
  localparam logic [2:0]  TC0_CS_DIV1024  = 3'h5;
  localparam logic [2:0]  TC0_CS_EXT_FALL = 3'h6;
  localparam int unsigned TC0_TAP_8       = 3;
  localparam int unsigned TC0_TAP_64      = 6;
  localparam int unsigned TC0_TAP_256     = 8;
  localparam int unsigned TC0_PRESCALE_W  = 10;
endpackage : tc0_pkg

// *** core/tc0_tick_gen.sv ***
/*
  Timer tick source: prescaler taps of the system clock or an edge of the
  external count input, one-cycle enable pulse out.
  Assumes the external count input is already synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module tc0_tick_gen
  import tc0_pkg::*;
#(
  parameter int unsigned PRESCALE_W = TC0_PRESCALE_W
)
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] clock_select,
  input  wire logic       timer_power_off,
  input  wire logic       ext_count_input,
  output wire logic       timer_tick
);
  logic [PRESCALE_W-1:0] prescale;
  logic                  ext_prev;

  // Prescaler only runs while a source is chosen and power is on
  wire run = (clock_select != TC0_CS_STOP) && !timer_power_off;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prescale <= '0;
      ext_prev <= 1'b0;
    end
    else
    begin
      prescale <= run ? prescale + 1'b1 : '0;
      ext_prev <= ext_count_input;
    end
  end

  // Tap hits: all low bits of the prescaler set
  wire hit8    = &prescale[TC0_TAP_8-1:0];
  wire hit64   = &prescale[TC0_TAP_64-1:0];
  wire hit256  = &prescale[TC0_TAP_256-1:0];
  wire hit1024 = &prescale;
  wire ext_rise = ext_count_input & ~ext_prev;
  wire ext_fall = ~ext_count_input & ext_prev;

  // Source select; stop code gives no tick at all
  wire sel_tick =
    (clock_select == TC0_CS_STOP)     ? 1'b0 :
    (clock_select == TC0_CS_DIV1)     ? 1'b1 :
    (clock_select == TC0_CS_DIV8)     ? hit8 :
    (clock_select == TC0_CS_DIV64)    ? hit64 :
    (clock_select == TC0_CS_DIV256)   ? hit256 :
    (clock_select == TC0_CS_DIV1024)  ? hit1024 :
    (clock_select == TC0_CS_EXT_FALL) ? ext_fall : ext_rise;

  // Single-cycle enable, never a derived clock
  assign timer_tick = sel_tick & !timer_power_off;
endmodule : tc0_tick_gen
`default_nettype wire

// *** core/tc0_timer_core.sv ***
/*
  8-bit timer/counter with two output compare units, AXI4-Lite registers.
  Assumes one clock, synchronous active-low reset, synchronous pin inputs,
  and a CPU that acknowledges serviced interrupts on the ack inputs.
*/
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tc0_timer_core
  import tc0_pkg::*;
#(
  parameter int unsigned PRESCALE_W = TC0_PRESCALE_W
)
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [TC0_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [TC0_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  ext_count_input,
  input  wire logic                  irq_ack_overflow,
  input  wire logic                  irq_ack_compare_a,
  input  wire logic                  irq_ack_compare_b,
  output var  logic                  irq_overflow,
  output var  logic                  irq_compare_a,
  output var  logic                  irq_compare_b,
  output wire logic                  compare_out_a,
  output wire logic                  compare_out_b
);
  // Software-visible state
  logic [7:0] timer_ctrl_a;
  logic       waveform_mode_bit2;
  logic [2:0] clock_select;
  logic [7:0] count_value_reg;
  logic [7:0] cmp_buf [2];
  logic [7:0] cmp_act [2];
  logic [2:0] timer_mask_reg;
  logic [2:0] timer_flag_reg;
  logic       timer_power_off;

  // Internal state
  logic       count_down;
  logic       block_pending;
  logic [1:0] oc_state;
  logic [1:0] match_evt;

  // Bus slave state
  logic                  aw_full;
  logic                  w_full;
  logic [TC0_ADDR_W-1:0] waddr;
  logic [7:0]            wbyte;
  logic                  wlane;

  wire timer_tick;

  // Tick source
  tc0_tick_gen #(
    .PRESCALE_W (PRESCALE_W)
  ) u_tick (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .clock_select    (clock_select),
    .timer_power_off (timer_power_off),
    .ext_count_input (ext_count_input),
    .timer_tick      (timer_tick)
  );

  // Write channel handshakes
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_full & w_full & ~s_axi_bvalid;
  wire next_aw_full = (aw_full | aw_take) & ~do_write;
  wire next_w_full  = (w_full | w_take) & ~do_write;

  // Write decode; only the low byte lane holds register bits
  wire       wr_en   = do_write & wlane;
  wire       w_hit   = waddr[TC0_ADDR_W-1:2] <= TC0_OFF_POWER[TC0_ADDR_W-1:2];
  wire [5:0] wa      = {waddr[TC0_ADDR_W-1:2], 2'b00};
  wire wr_ctrl_a = wr_en & (wa == TC0_OFF_CTRL_A);
  wire wr_ctrl_b = wr_en & (wa == TC0_OFF_CTRL_B);
  wire wr_count  = wr_en & (wa == TC0_OFF_COUNT);
  wire wr_mask   = wr_en & (wa == TC0_OFF_MASK);
  wire wr_flag   = wr_en & (wa == TC0_OFF_FLAG);
  wire wr_power  = wr_en & (wa == TC0_OFF_POWER);
  wire [1:0] wr_cmp = {wr_en & (wa == TC0_OFF_CMP_B), wr_en & (wa == TC0_OFF_CMP_A)};
  wire [1:0] force_wr = {2{wr_ctrl_b}} & {wbyte[TC0_CB_FORCE_B], wbyte[TC0_CB_FORCE_A]};

  // Write channel control; one write in flight
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      waddr         <= '0;
      wbyte         <= TC0_RST_BYTE;
      wlane         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= TC0_RESP_OK;
    end
    else
    begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= ~next_aw_full;
      s_axi_wready  <= ~next_w_full;
      if (aw_take)
        waddr <= s_axi_awaddr;
      if (w_take)
      begin
        wbyte <= s_axi_wdata[7:0];
        wlane <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_hit ? TC0_RESP_OK : TC0_RESP_ERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Mode decode
  wire [2:0] waveform_mode = {waveform_mode_bit2, timer_ctrl_a[TC0_CA_WAVE +: 2]};
  wire is_pwm   = waveform_mode[0];
  wire is_fast  = waveform_mode[1:0] == TC0_WAVE_FAST[1:0];
  wire is_phase = is_pwm & ~is_fast;
  wire is_ctc   = waveform_mode == TC0_WAVE_CTC;
  wire top_is_a = waveform_mode[2] | is_ctc;

  // Extremes and top of sequence
  wire       at_bottom = count_value_reg == TC0_BOTTOM;
  wire       at_max    = count_value_reg == TC0_MAX;
  wire [7:0] top_value = top_is_a ? cmp_act[0] : TC0_MAX;
  wire       at_top    = count_value_reg == top_value;

  // Count sequence on a tick
  wire clear_now   = (is_fast | is_ctc) & at_top;
  wire next_down   = is_phase & (count_down ? ~at_bottom : at_top);
  wire [7:0] stepped = next_down ? count_value_reg - 8'h01 : count_value_reg + 8'h01;
  wire [7:0] next_count = clear_now ? TC0_BOTTOM : stepped;

  // Overflow point per mode
  wire ovf_evt = timer_tick & (is_phase ? (at_bottom & count_down)
                              : is_fast ? at_top : at_max);

  // Buffered compare copies at top in PWM modes
  wire buf_load = is_pwm & timer_tick & at_top;

  // Counter, direction and match blocking
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_value_reg <= TC0_RST_BYTE;
      count_down      <= 1'b0;
      block_pending   <= 1'b0;
    end
    else
    begin
      if (wr_count)
        count_value_reg <= wbyte;
      else if (timer_tick)
        count_value_reg <= next_count;
      if (!is_phase)
        count_down <= 1'b0;
      else if (timer_tick)
        count_down <= next_down;
      if (wr_count)
        block_pending <= 1'b1;
      else if (timer_tick)
        block_pending <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_ctrl_a       <= TC0_RST_BYTE;
      waveform_mode_bit2 <= 1'b0;
      clock_select       <= TC0_CS_STOP;
      timer_mask_reg     <= TC0_RST_FLAGS;
      timer_power_off    <= TC0_RST_PWR;
    end
    else
    begin
      if (wr_ctrl_a)
        timer_ctrl_a <= wbyte;
      if (wr_ctrl_b)
      begin
        waveform_mode_bit2 <= wbyte[TC0_CB_WAVE2];
        clock_select       <= wbyte[TC0_CB_CS +: 3];
      end
      if (wr_mask)
        timer_mask_reg <= wbyte[2:0];
      if (wr_power)
        timer_power_off <= wbyte[TC0_PWR_OFF];
    end
  end

  // Flags: set wins over clear by one-write or service
  wire [2:0] flag_set = {match_evt, ovf_evt};
  wire [2:0] flag_w1c = wr_flag ? wbyte[2:0] : 3'h0;
  wire [2:0] flag_ack = {irq_ack_compare_b, irq_ack_compare_a, irq_ack_overflow};
  wire [2:0] next_flag = (timer_flag_reg & ~(flag_w1c | flag_ack)) | flag_set;
  wire [2:0] next_irq  = next_flag & timer_mask_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_flag_reg <= TC0_RST_FLAGS;
      irq_overflow   <= 1'b0;
      irq_compare_a  <= 1'b0;
      irq_compare_b  <= 1'b0;
    end
    else
    begin
      timer_flag_reg <= next_flag;
      irq_overflow   <= next_irq[TC0_FL_OVF];
      irq_compare_a  <= next_irq[TC0_FL_CMP_A];
      irq_compare_b  <= next_irq[TC0_FL_CMP_B];
    end
  end

  // Per-channel compare unit: buffer, match, waveform output
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_cmp
      wire [1:0] act = timer_ctrl_a[TC0_CA_ACT_A - 2*ch +: 2];
      wire       oc  = oc_state[ch];
      // Match every cycle; counted only on an unblocked tick
      wire       match = count_value_reg == cmp_act[ch];
      assign match_evt[ch] = timer_tick & match & ~(block_pending | wr_count);
      // Force acts only outside PWM and touches no flag or count
      wire       forced = force_wr[ch] & ~is_pwm;
      wire       np_hit = ~is_pwm & (match_evt[ch] | forced);
      wire       np_lvl = (act == TC0_ACT_TOGGLE) ? ~oc :
                          (act == TC0_ACT_SET)    ? 1'b1 :
                          (act == TC0_ACT_CLEAR)  ? 1'b0 : oc;
      // PWM: inverting choice, phase flips on the down slope
      wire       inv     = act == TC0_ACT_SET;
      wire       m_lvl   = inv ^ count_down;
      wire       at_bot  = timer_tick & is_fast & at_top;
      wire       pwm_on  = is_pwm & act[1];
      wire       pwm_tog = is_pwm & (act == TC0_ACT_TOGGLE) & (ch == 0) & waveform_mode[2];
      wire       next_oc = np_hit                   ? np_lvl :
                           (pwm_on & at_bot)        ? ~inv :
                           (pwm_on & match_evt[ch]) ? m_lvl :
                           (pwm_tog & match_evt[ch]) ? ~oc : oc;

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cmp_buf[ch]  <= TC0_RST_BYTE;
          cmp_act[ch]  <= TC0_RST_BYTE;
          oc_state[ch] <= 1'b0;
        end
        else
        begin
          if (wr_cmp[ch])
            cmp_buf[ch] <= wbyte;
          if (wr_cmp[ch] && !is_pwm)
            cmp_act[ch] <= wbyte;
          else if (buf_load)
            cmp_act[ch] <= cmp_buf[ch];
          oc_state[ch] <= next_oc;
        end
      end
    end
  endgenerate

  assign compare_out_a = oc_state[0];
  assign compare_out_b = oc_state[1];

  // Read data selection; force strobes read as zero
  wire [TC0_ADDR_W-3:0] ridx = s_axi_araddr[TC0_ADDR_W-1:2];
  wire       r_hit = ridx <= TC0_OFF_POWER[TC0_ADDR_W-1:2];
  wire [5:0] ra    = {ridx, 2'b00};
  wire [7:0] ctrl_b_rd = {4'h0, waveform_mode_bit2, clock_select};
  wire [7:0] rd_byte =
    (ra == TC0_OFF_CTRL_A) ? timer_ctrl_a :
    (ra == TC0_OFF_CTRL_B) ? ctrl_b_rd :
    (ra == TC0_OFF_COUNT)  ? count_value_reg :
    (ra == TC0_OFF_CMP_A)  ? cmp_buf[0] :
    (ra == TC0_OFF_CMP_B)  ? cmp_buf[1] :
    (ra == TC0_OFF_MASK)   ? {5'h00, timer_mask_reg} :
    (ra == TC0_OFF_FLAG)   ? {5'h00, timer_flag_reg} :
    (ra == TC0_OFF_POWER)  ? {7'h00, timer_power_off} : 8'h00;

  // Read channel; one read in flight
  wire ar_take    = s_axi_arvalid & s_axi_arready;
  wire next_rbusy = (s_axi_rvalid & ~s_axi_rready) | ar_take;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= TC0_RESP_OK;
    end
    else
    begin
      s_axi_arready <= ~next_rbusy;
      s_axi_rvalid  <= next_rbusy;
      if (ar_take)
      begin
        s_axi_rdata <= {24'h00_0000, r_hit ? rd_byte : 8'h00};
        s_axi_rresp <= r_hit ? TC0_RESP_OK : TC0_RESP_ERR;
      end
    end
  end
endmodule : tc0_timer_core
`default_nettype wire

// *** test/tc0_timer_chk.sv ***
/*
  Port checker for the timer core: bus answer timing and flag clearing.
  Assumes one clock, synchronous active-low reset, bound to the core.
*/
`timescale 1ns/1ps
`default_nettype none
module tc0_timer_chk
  import tc0_pkg::*;
#(
  parameter int unsigned PRESCALE_W = TC0_PRESCALE_W
)
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [TC0_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic [3:0]            s_axi_wstrb,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [TC0_ADDR_W-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic                  irq_overflow,
  input wire logic                  irq_ack_compare_b,
  input wire logic                  irq_compare_b
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write address and data taken together
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Bus answer timing and holding
  property p_wr_lat;
    s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late or early");
  property p_wr_err;
    s_wr_take ##0 (s_axi_awaddr >= 6'h20) |=> ##1 s_axi_bresp == TC0_RESP_ERR;
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_lat;
    s_rd_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_err;
    s_rd_take ##0 (s_axi_araddr >= 6'h20) |=> s_axi_rresp == TC0_RESP_ERR && s_axi_rdata == 0;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_rd_width;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_width: assert property (p_rd_width) else $error("read data wider than a byte");
  // Flag clearing by write and by service
  property p_ovf_w1c;
    s_wr_take ##0 (s_axi_awaddr == TC0_OFF_FLAG && s_axi_wdata[0] && s_axi_wstrb[0])
      |=> ##[1:2] !irq_overflow;
  endproperty
  a_ovf_w1c: assert property (p_ovf_w1c) else $error("overflow not cleared");
  property p_ack_b;
    irq_ack_compare_b |=> ##[0:1] !irq_compare_b;
  endproperty
  a_ack_b: assert property (p_ack_b) else $error("service did not clear flag");
endmodule : tc0_timer_chk
bind tc0_timer_core tc0_timer_chk #(.PRESCALE_W(PRESCALE_W)) i_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq_overflow, .irq_ack_compare_b, .irq_compare_b
);
`default_nettype wire

// *** test/tc0_cpu_model.sv ***
/*
  Host CPU model: AXI4-Lite master tasks and an interrupt service pulse.
  Assumes the core answers on its own; waits end only by the bench watchdog.
*/
`timescale 1ns/1ps
`default_nettype none
module tc0_cpu_model
  import tc0_pkg::*;
(
  input  wire logic                  aclk,
  output var  logic [TC0_ADDR_W-1:0] s_axi_awaddr,
  output var  logic                  s_axi_awvalid,
  input  wire logic                  s_axi_awready,
  output var  logic [31:0]           s_axi_wdata,
  output var  logic [3:0]            s_axi_wstrb,
  output var  logic                  s_axi_wvalid,
  input  wire logic                  s_axi_wready,
  input  wire logic [1:0]            s_axi_bresp,
  input  wire logic                  s_axi_bvalid,
  output var  logic                  s_axi_bready,
  output var  logic [TC0_ADDR_W-1:0] s_axi_araddr,
  output var  logic                  s_axi_arvalid,
  input  wire logic                  s_axi_arready,
  input  wire logic [31:0]           s_axi_rdata,
  input  wire logic [1:0]            s_axi_rresp,
  input  wire logic                  s_axi_rvalid,
  output var  logic                  s_axi_rready,
  output var  logic                  irq_ack_compare_b
);
  // Idle bus at time zero
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, irq_ack_compare_b} = '0;
    s_axi_wstrb = 4'hF;
  end
  // One write: address and data offered together, each released when taken
  task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        s_axi_wvalid <= 1'b0;
        w_done = 1;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // One read: answer taken at the edge rvalid is seen
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Service of the compare B interrupt, one cycle
  task automatic ack_b();
    @(posedge aclk);
    irq_ack_compare_b <= 1'b1;
    @(posedge aclk);
    irq_ack_compare_b <= 1'b0;
  endtask : ack_b
endmodule : tc0_cpu_model
`default_nettype wire

// *** test/tb_top.sv ***
/*
  Self-checking bench of the timer core, register access through the CPU model.
  Assumes a 200 MHz clock and the full prescaler width.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; $display("MISMATCH t=%0t act=%h exp=%h", $time, a, e); end end
module tb_top
  import tc0_pkg::*;
;
  logic                  aclk, aresetn, ext_count_input, irq_ack_compare_b;
  logic [TC0_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  logic                  irq_overflow, irq_compare_a, irq_compare_b;
  logic                  compare_out_a, compare_out_b;
  int                    n_errors, checked;
  logic [1:0]            acts [5] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h2};
  logic                  outs [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  // Core and host
  tc0_timer_core #(.PRESCALE_W(TC0_PRESCALE_W)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_count_input, .irq_ack_overflow(1'b0),
    .irq_ack_compare_a(1'b0), .irq_ack_compare_b, .irq_overflow, .irq_compare_a,
    .irq_compare_b, .compare_out_a, .compare_out_b
  );
  tc0_cpu_model i_cpu (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq_ack_compare_b
  );
  task automatic print_verdict();
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    logic [1:0] r;
    i_cpu.wr(a, d, r);
    `CHK(r, TC0_RESP_OK)
  endtask : wreg
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    i_cpu.rd(a, d, r);
    `CHK(d, {24'h0, e})
  endtask : rchk
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    print_verdict();
  end
  // Test sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    aresetn = 1'b0;
    ext_count_input = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(TC0_OFF_COUNT, 8'h00);
    rchk(TC0_OFF_CMP_A, 8'h00);
    i_cpu.rd(6'h20, d, r);
    `CHK(r, TC0_RESP_ERR)
    i_cpu.wr(6'h24, 8'h11, r);
    `CHK(r, TC0_RESP_ERR)
    wreg(TC0_OFF_CMP_A, 8'hA5);
    rchk(TC0_OFF_CMP_A, 8'hA5);
    wreg(TC0_OFF_CMP_B, 8'h5A);
    rchk(TC0_OFF_CMP_B, 8'h5A);
    wreg(TC0_OFF_COUNT, 8'h10);
    repeat (20) @(posedge aclk);
    rchk(TC0_OFF_COUNT, 8'h10);
    // Power-off holds a running selection
    wreg(TC0_OFF_POWER, 8'h01);
    wreg(TC0_OFF_CTRL_B, 8'h01);
    repeat (20) @(posedge aclk);
    rchk(TC0_OFF_COUNT, 8'h10);
    wreg(TC0_OFF_CTRL_B, 8'h00);
    wreg(TC0_OFF_POWER, 8'h00);
    // Wrap in normal mode, then write-one clearing
    wreg(TC0_OFF_MASK, 8'h07);
    wreg(TC0_OFF_COUNT, 8'hF0);
    wreg(TC0_OFF_CTRL_B, 8'h01);
    repeat (30) @(posedge aclk);
    wreg(TC0_OFF_CTRL_B, 8'h00);
    `CHK(irq_overflow, 1'b1)
    rchk(TC0_OFF_FLAG, 8'h01);
    wreg(TC0_OFF_FLAG, 8'h06);
    rchk(TC0_OFF_FLAG, 8'h01);
    wreg(TC0_OFF_FLAG, 8'h01);
    rchk(TC0_OFF_FLAG, 8'h00);
    // Compare B match, interrupt, service
    wreg(TC0_OFF_COUNT, 8'h50);
    wreg(TC0_OFF_CTRL_B, 8'h01);
    repeat (30) @(posedge aclk);
    wreg(TC0_OFF_CTRL_B, 8'h00);
    `CHK(irq_compare_b, 1'b1)
    `CHK(irq_compare_a, 1'b0)
    rchk(TC0_OFF_FLAG, 8'h04);
    i_cpu.ack_b();
    repeat (2) @(posedge aclk);
    `CHK(irq_compare_b, 1'b0)
    rchk(TC0_OFF_FLAG, 8'h00);
    // Count written equal to compare B blocks the first match
    wreg(TC0_OFF_COUNT, 8'h5A);
    wreg(TC0_OFF_CTRL_B, 8'h01);
    repeat (10) @(posedge aclk);
    wreg(TC0_OFF_CTRL_B, 8'h00);
    rchk(TC0_OFF_FLAG, 8'h00);
    // Forced compare with every action code
    for (int i = 0; i < 5; i++)
    begin
      wreg(TC0_OFF_CTRL_A, {acts[i], acts[i], 4'h0});
      wreg(TC0_OFF_CTRL_B, 8'hC0);
      `CHK(compare_out_a, outs[i])
      `CHK(compare_out_b, outs[i])
    end
    rchk(TC0_OFF_COUNT, 8'h68);
    rchk(TC0_OFF_FLAG, 8'h00);
    // Clear-on-match keeps the count at or below compare A
    wreg(TC0_OFF_CTRL_A, 8'h02);
    wreg(TC0_OFF_CMP_A, 8'h05);
    wreg(TC0_OFF_COUNT, 8'h00);
    wreg(TC0_OFF_CTRL_B, 8'h01);
    repeat (6)
    begin
      i_cpu.rd(TC0_OFF_COUNT, d, r);
      `CHK(d <= 32'h0000_0005, 1'b1)
    end
    wreg(TC0_OFF_CTRL_B, 8'h00);
    // Prescaled then external ticks, B write buffered
    wreg(TC0_OFF_CTRL_A, 8'h03);
    wreg(TC0_OFF_CMP_B, 8'h07);
    wreg(TC0_OFF_COUNT, 8'h00);
    wreg(TC0_OFF_CTRL_B, 8'h02);
    repeat (40) @(posedge aclk);
    wreg(TC0_OFF_CTRL_B, 8'h07);
    repeat (8)
    begin
      repeat (2) @(posedge aclk);
      ext_count_input <= ~ext_count_input;
    end
    repeat (2) @(posedge aclk);
    rchk(TC0_OFF_COUNT, 8'h09);
    rchk(TC0_OFF_FLAG, 8'h02);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
